// File: src/qrspi_bank.sv
// Purpose: One of the four parallel storage arrays, one word per address.
// Assumes: Lane enables are active high; read is from the stored state.
// Notes:   Only SAW low address bits are stored; higher bits alias.
`timescale 1ns/1ps
`include "qrspi_defines.svh"

module qrspi_bank #(
  parameter int DW  = 36,
  parameter int ML  = 4,
  parameter int SAW = 4
) (
  // Clock and reset.
  input wire logic    clk,
  input wire logic    resetn,
  // Access from the core.
  qrspi_bank_if.bank  p
);
  localparam int LW    = DW / ML;
  localparam int DEPTH = 1 << SAW;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] word;
  } qrspi_bank_st_t;

  qrspi_bank_st_t st;
  qrspi_bank_st_t next_st;

  // Writes only the enabled lanes; masked lanes keep their contents.
  always_comb begin
    next_st = st;
    if (p.we) begin
      for (int l = 0; l < ML; l++) begin
        if (p.lane_en[l]) begin
          next_st.word[p.wr_idx][l*LW +: LW] = p.wr_data[l*LW +: LW];
        end
      end
    end
  end

  // Registers the whole array.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Read port sees the stored word at the read index.
  assign p.rd_data = st.word[p.rd_idx];

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_LANE_HOLD: assert property (
    (p.we && !p.lane_en[0]) |=>
      st.word[$past(p.wr_idx)][LW-1:0] ==
      $past(st.word[p.wr_idx][LW-1:0]))
    else $error("Masked lane zero was altered.");

  COV_MASKED_WRITE: cover property (p.we && !p.lane_en[0] && p.lane_en[1]);

endmodule : qrspi_bank

// File: src/qrspi_defines.svh
// Purpose: Named constants for the quad rate memory port block.
// Assumes: Included by bare name from the design files.
// Notes:   Holds definitions only.
`ifndef QRSPI_DEFINES_SVH
`define QRSPI_DEFINES_SVH

// Burst shape: four beats per access, two bits of beat index.
`define QRSPI_BEATS       4
`define QRSPI_BEAT_W      2
`define QRSPI_FIRST_BEAT  2'h0
`define QRSPI_NEXT_BEAT   2'h1
`define QRSPI_LAST_BEAT   2'h3

// Phase of the internal clock pair: this value marks the positive edge.
`define QRSPI_PHASE_RISE  1'h0

// Lane layout per configuration.
`define QRSPI_NIBBLE_DW   8
`define QRSPI_NIBBLE_LANES 2
`define QRSPI_LANE_BITS   9

// Address width per configuration.
`define QRSPI_DW_MID      18
`define QRSPI_AW_NARROW   21
`define QRSPI_AW_MID      20
`define QRSPI_AW_WIDE     19

// Cycles from an accepted read select to its first output beat.
`define QRSPI_RD_LAT      2

`endif

// File: src/qrspi_ifs.sv
// Purpose: Carriers between the core and its array and output stage.
// Assumes: One clock domain; no clocking blocks.
// Notes:   Parameters follow the instantiating core.
`timescale 1ns/1ps

// Write and read access to one of the four storage arrays.
interface qrspi_bank_if #(
  parameter int DW  = 36,
  parameter int ML  = 4,
  parameter int SAW = 4
);
  logic           we;
  logic [SAW-1:0] wr_idx;
  logic [DW-1:0]  wr_data;
  logic [ML-1:0]  lane_en;
  logic [SAW-1:0] rd_idx;
  logic [DW-1:0]  rd_data;

  modport core (output we, output wr_idx, output wr_data, output lane_en,
                output rd_idx, input rd_data);
  modport bank (input we, input wr_idx, input wr_data, input lane_en,
                input rd_idx, output rd_data);
endinterface : qrspi_bank_if

// One read beat handed from the core to the output registers.
interface qrspi_out_if #(
  parameter int DW = 36
);
  logic          beat_vld;
  logic [DW-1:0] beat_data;

  modport core  (output beat_vld, output beat_data);
  modport stage (input beat_vld, input beat_data);
endinterface : qrspi_out_if

// File: src/qrspi_out_stage.sv
// Purpose: Output registers of the read port with enable and valid flag.
// Assumes: One beat per clock arrives from the core.
// Notes:   Data is zero and the enable low whenever no beat is valid.
`timescale 1ns/1ps
`include "qrspi_defines.svh"

module qrspi_out_stage #(
  parameter int DW = 36
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          resetn,
  // Beats from the core.
  qrspi_out_if.stage         p,
  // Read pins.
  output logic [DW-1:0]      rd_data,
  output logic               rd_data_oe,
  output logic               out_valid_flag
);
  typedef struct packed {
    logic [DW-1:0] q;
    logic          vld;
  } qrspi_out_st_t;

  qrspi_out_st_t st;
  qrspi_out_st_t next_st;

  // Launches one beat per clock; floats the pins when no beat is due.
  always_comb begin
    next_st.vld = p.beat_vld;
    next_st.q   = p.beat_vld ? p.beat_data : '0;
  end

  // Registers the output state.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Pins come straight from the flops.
  assign rd_data        = st.q;
  assign rd_data_oe     = st.vld;
  assign out_valid_flag = st.vld;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_BEAT_OUT: assert property (
    p.beat_vld |=> (rd_data == $past(p.beat_data)) && out_valid_flag)
    else $error("Read beat not launched on the next clock.");

  AST_FLOAT: assert property (
    !p.beat_vld |=> !rd_data_oe && !out_valid_flag)
    else $error("Read pins driven without a valid beat.");

endmodule : qrspi_out_stage

// File: src/qrspi_pkg.sv
// Purpose: Shared types of the quad rate memory port block.
// Assumes: Nothing is imported; users write qrspi_pkg::name.
// Notes:   Port state is one bit, so every code is legal.
package qrspi_pkg;

  // State of one port: idle or within a four beat burst.
  typedef enum logic [0:0] {
    QRSPI_IDLE = 1'b0,
    QRSPI_BUSY = 1'b1
  } qrspi_port_st_t;

endpackage : qrspi_pkg

// File: src/qrspi_port.sv
// Purpose: Burst-of-four memory with separate write and read ports.
// Assumes: One clock; each clock is one beat, the positive input
//          clock edge falling on every second clock, the negative one
//          between. Inputs are synchronous to clk.
// Notes:   Storage depth is reduced by STORE_AW for simulation.
// Functional notes
// - Write data is captured on every beat while a write is active.
// - Low write select on a positive edge starts a write; a read starting on that edge blocks it.
// - High write select deselects writes; data is ignored.
// - Eight-bit form: two nibble masks gate bits 3:0 and 7:4 per beat.
// - A high nibble mask discards that nibble; memory stays unchanged.
// - Wider forms: lane masks gate 9-bit lanes on each beat.
// - A high lane mask leaves that stored lane unaltered.
// - Shared address is sampled on positive edges for reads and writes.
// - Address is 21, 20 or 19 bits by data width.
// - Four parallel arrays; one address gives four burst words.
// - Address is ignored on edges where the port is deselected.
// - Read data launches a new beat on both edges.
// - Read outputs float on clocks that carry no read beat.
// - Low read select starts four transfers; pending burst completes.
// - A valid flag marks beats carrying read data.
// - Accesses start only on positive edges; other edges carry beats.
`timescale 1ns/1ps
`include "qrspi_defines.svh"

module qrspi_port #(
  parameter int DW       = 36,
  parameter int AW       = (DW <= `QRSPI_LANE_BITS) ? `QRSPI_AW_NARROW :
                           (DW == `QRSPI_DW_MID)    ? `QRSPI_AW_MID :
                                                      `QRSPI_AW_WIDE,
  parameter int STORE_AW = 4
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          resetn,
  // Edge marker: high in clocks that stand for a positive edge.
  output logic               k_rise,
  // Shared address.
  input  wire logic [AW-1:0] addr,
  // Write port.
  input  wire logic          write_port_sel_n,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          nibble_mask_lo_n,
  input  wire logic          nibble_mask_hi_n,
  input  wire logic          lane_mask0_n,
  input  wire logic          lane_mask1_n,
  input  wire logic          lane_mask2_n,
  input  wire logic          lane_mask3_n,
  // Read port.
  input  wire logic          read_port_sel_n,
  output logic [DW-1:0]      rd_data,
  output logic               rd_data_oe,
  output logic               out_valid_flag
);
  localparam int ML = (DW == `QRSPI_NIBBLE_DW) ? `QRSPI_NIBBLE_LANES
                                               : DW / `QRSPI_LANE_BITS;
  localparam int SAW = (STORE_AW < AW) ? STORE_AW : AW;

  typedef struct packed {
    logic                      k_phase;
    qrspi_pkg::qrspi_port_st_t wr_st;
    logic [`QRSPI_BEAT_W-1:0]  wr_beat;
    logic [AW-1:0]             wr_addr;
    qrspi_pkg::qrspi_port_st_t rd_st;
    logic [`QRSPI_BEAT_W-1:0]  rd_beat;
    logic [AW-1:0]             rd_addr;
  } qrspi_core_t;

  qrspi_core_t                     st;
  qrspi_core_t                     next_st;
  logic                            k_edge;
  logic                            rd_free;
  logic                            rd_start;
  logic                            wr_start;
  logic                            wr_go;
  logic [3:0]                      all_mask_n;
  logic [ML-1:0]                   lane_mask_n;
  logic [`QRSPI_BEATS-1:0][DW-1:0] bank_rd;

  // Selects the mask pins that belong to this data width.
  always_comb begin
    if (DW == `QRSPI_NIBBLE_DW) begin
      all_mask_n = {2'h3, nibble_mask_hi_n, nibble_mask_lo_n};
    end else begin
      all_mask_n = {lane_mask3_n, lane_mask2_n,
                    lane_mask1_n, lane_mask0_n};
    end
    lane_mask_n = all_mask_n[ML-1:0];
  end

  // Decodes the edge phase and which accesses start on this clock.
  always_comb begin
    k_edge   = (st.k_phase == `QRSPI_PHASE_RISE);
    rd_free  = (st.rd_st == qrspi_pkg::QRSPI_IDLE) ||
               (st.rd_beat == `QRSPI_LAST_BEAT);
    // Selects count only on positive edges and an idle port, or a read port on its last beat.
    rd_start = k_edge && !read_port_sel_n && rd_free;
    // A read on the same edge owns the shared address.
    wr_start = k_edge && !write_port_sel_n && !rd_start &&
               (st.wr_st == qrspi_pkg::QRSPI_IDLE);
    wr_go    = wr_start || (st.wr_st == qrspi_pkg::QRSPI_BUSY);
  end

  // Next state of the edge phase and both port sequencers.
  always_comb begin
    next_st         = st;
    next_st.k_phase = ~st.k_phase;
    // Write: beat zero lands on the start clock, beats one to three after.
    unique case (st.wr_st)
      qrspi_pkg::QRSPI_IDLE: begin
        if (wr_start) begin
          next_st.wr_st   = qrspi_pkg::QRSPI_BUSY;
          next_st.wr_beat = `QRSPI_NEXT_BEAT;
          next_st.wr_addr = addr;
        end
      end
      qrspi_pkg::QRSPI_BUSY: begin
        next_st.wr_beat = st.wr_beat + `QRSPI_NEXT_BEAT;
        if (st.wr_beat == `QRSPI_LAST_BEAT) begin
          next_st.wr_st = qrspi_pkg::QRSPI_IDLE;
        end
      end
    endcase
    // Read: a new burst may start on the clock of the last beat.
    unique case (st.rd_st)
      qrspi_pkg::QRSPI_IDLE: begin
        if (rd_start) begin
          next_st.rd_st   = qrspi_pkg::QRSPI_BUSY;
          next_st.rd_beat = `QRSPI_FIRST_BEAT;
          next_st.rd_addr = addr;
        end
      end
      qrspi_pkg::QRSPI_BUSY: begin
        if (rd_start) begin
          next_st.rd_beat = `QRSPI_FIRST_BEAT;
          next_st.rd_addr = addr;
        end else if (st.rd_beat == `QRSPI_LAST_BEAT) begin
          next_st.rd_st = qrspi_pkg::QRSPI_IDLE;
        end else begin
          next_st.rd_beat = st.rd_beat + `QRSPI_NEXT_BEAT;
        end
      end
    endcase
  end

  // Registers the core state; the first clock after reset is a positive edge.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign k_rise = k_edge;

  // Four parallel arrays, one per beat of the burst.
  for (genvar b = 0; b < `QRSPI_BEATS; b++) begin : g_bank
    localparam logic [`QRSPI_BEAT_W-1:0] BN = `QRSPI_BEAT_W'(b);

    qrspi_bank_if #(.DW(DW), .ML(ML), .SAW(SAW)) bif ();

    // Each beat of a write goes to its own array with its own masks.
    assign bif.we      = (wr_start && (BN == `QRSPI_FIRST_BEAT)) ||
                         ((st.wr_st == qrspi_pkg::QRSPI_BUSY) &&
                          (st.wr_beat == BN));
    assign bif.wr_idx  = wr_start ? addr[SAW-1:0]
                                  : st.wr_addr[SAW-1:0];
    assign bif.wr_data = wr_data;
    assign bif.lane_en = ~lane_mask_n;
    assign bif.rd_idx  = st.rd_addr[SAW-1:0];
    assign bank_rd[b]  = bif.rd_data;

    qrspi_bank #(
      .DW  (DW),
      .ML  (ML),
      .SAW (SAW)
    ) u_bank (
      .clk    (clk),
      .resetn (resetn),
      .p      (bif.bank)
    );
  end

  qrspi_out_if #(.DW(DW)) oif ();

  // Hands the current read beat to the output registers.
  assign oif.beat_vld  = (st.rd_st == qrspi_pkg::QRSPI_BUSY);
  assign oif.beat_data = bank_rd[st.rd_beat];

  qrspi_out_stage #(
    .DW (DW)
  ) u_out (
    .clk            (clk),
    .resetn         (resetn),
    .p              (oif.stage),
    .rd_data        (rd_data),
    .rd_data_oe     (rd_data_oe),
    .out_valid_flag (out_valid_flag)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_WR_BEATS: assert property (
    wr_start |-> wr_go [*4] ##1 (st.wr_st == qrspi_pkg::QRSPI_IDLE))
    else $error("Write burst did not capture exactly four beats.");

  AST_WR_DESEL: assert property (
    (k_edge && write_port_sel_n && st.wr_st == qrspi_pkg::QRSPI_IDLE)
      |-> !wr_go)
    else $error("Write started with the write port deselected.");

  AST_LANE_GATE: assert property (
    wr_go |-> (g_bank[0].bif.lane_en == ~all_mask_n[ML-1:0]))
    else $error("Lane enables do not follow the mask pins.");

  AST_START_EDGE: assert property (
    (wr_start || rd_start) |-> (st.k_phase == `QRSPI_PHASE_RISE))
    else $error("Access started off a positive edge.");

  AST_ADDR_TAKE: assert property (
    rd_start |=> (st.rd_addr == $past(addr)))
    else $error("Read address not taken on the start edge.");

  AST_ADDR_IGNORE: assert property (
    (read_port_sel_n && st.rd_st == qrspi_pkg::QRSPI_BUSY)
      |=> $stable(st.rd_addr))
    else $error("Read address moved while the read port was deselected.");

  AST_RD_BURST: assert property (
    rd_start |-> ##2 out_valid_flag [*4])
    else $error("Read burst did not show four valid beats.");

  AST_RD_END: assert property (
    (rd_start ##1 (read_port_sel_n || !k_edge) [*4]) |-> ##2 !rd_data_oe)
    else $error("Read pins still driven after the burst.");

  COV_RD_B2B: cover property (rd_start ##4 rd_start);
  COV_RD_WR:  cover property (rd_start ##2 wr_start);
  COV_WR_B2B: cover property (wr_start ##4 wr_start);

endmodule : qrspi_port

// File: verification/qrspi_ctrl_model.sv
// Purpose: Behavioural memory controller driving the port's inputs.
// Assumes: Tasks are entered at mid-clock; lines change on rising clk only.
// Notes:   Address, data and mask lines not in use toggle, so a stale value is never trusted.
`timescale 1ns/1ps

module qrspi_ctrl_model #(
  parameter int DW = 36,
  parameter int AW = 19
) (
  // Clock and edge marker from the port.
  input  wire logic          clk,
  input  wire logic          k_rise,
  // Controller outputs.
  output logic [AW-1:0]      addr,
  output logic               write_port_sel_n,
  output logic [DW-1:0]      wr_data,
  output logic [3:0]         lane_n,
  output logic               read_port_sel_n,
  output logic               hang
);
  logic wbusy;
  logic abusy;

  // Start with both ports deselected.
  initial begin
    addr             = '0;
    wr_data          = '0;
    lane_n           = 4'h0;
    write_port_sel_n = 1'h1;
    read_port_sel_n  = 1'h1;
    hang             = 1'h0;
    wbusy            = 1'h0;
    abusy            = 1'h0;
  end

  // Released lines show the inverse of their last value.
  always @(posedge clk) begin
    if (!abusy) addr <= ~addr;
    if (!wbusy) begin
      wr_data <= ~wr_data;
      lane_n  <= ~lane_n;
    end
  end

  // Waits until the coming clock stands for a positive edge.
  task automatic align();
    int i;
    for (i = 0; i < 4 && k_rise !== 1'h0; i++) @(negedge clk);
    if (k_rise !== 1'h0) hang = 1'h1;
  endtask : align

  // One write burst; skew places the select one clock late, off phase.
  task automatic wr(input logic [AW-1:0] a, input logic [3:0][DW-1:0] d,
                    input logic [3:0][3:0] m, input bit skew);
    int b;
    align();
    if (skew) @(negedge clk);
    wbusy = 1'h1;
    abusy = 1'h1;
    for (b = 0; b < 4; b++) begin
      @(posedge clk);
      write_port_sel_n <= (b != 0);
      addr             <= (b == 0) ? a : ~a;
      wr_data          <= d[b];
      lane_n           <= m[b];
    end
    @(negedge clk);
    wbusy = 1'h0;
    abusy = 1'h0;
  endtask : wr

  // Read request: select and address for one positive-edge clock.
  task automatic rd(input logic [AW-1:0] a);
    align();
    abusy = 1'h1;
    @(posedge clk);
    read_port_sel_n <= 1'h0;
    addr            <= a;
    @(posedge clk);
    read_port_sel_n <= 1'h1;
    addr            <= ~a;
    @(negedge clk);
    abusy = 1'h0;
  endtask : rd
endmodule : qrspi_ctrl_model

// File: verification/tb_quad_rate_sram_port_interface.sv
// Purpose: Self-checking bench of the burst-of-four memory port.
// Assumes: DW of 36, so the nibble masks are ignored; they follow lanes 0, 1.
// Notes:   Storage reduced to 16 words per array.
`timescale 1ns/1ps

module tb_quad_rate_sram_port_interface;
  localparam int     TB_DW = 36;
  localparam int     TB_AW = 19;
  logic              clk;
  logic              ph;
  logic              resetn;
  logic              k_rise;
  logic [18:0]       addr;
  logic              write_port_sel_n;
  logic [35:0]       wr_data;
  logic [3:0]        lane_n;
  logic              read_port_sel_n;
  logic [35:0]       rd_data;
  logic              rd_data_oe;
  logic              out_valid_flag;
  logic              hang;
  int                n_mismatch;
  int                check_count;
  int                cyc;
  logic [35:0]       q_dat[$];
  int                q_cyc[$];
  logic [3:0][35:0]  mem[16];

  qrspi_port #(.DW(TB_DW)) dut (
    .clk(clk), .resetn(resetn), .k_rise(k_rise), .addr(addr),
    .write_port_sel_n(write_port_sel_n), .wr_data(wr_data),
    .nibble_mask_lo_n(lane_n[0]), .nibble_mask_hi_n(lane_n[1]),
    .lane_mask0_n(lane_n[0]), .lane_mask1_n(lane_n[1]),
    .lane_mask2_n(lane_n[2]), .lane_mask3_n(lane_n[3]),
    .read_port_sel_n(read_port_sel_n), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .out_valid_flag(out_valid_flag));

  qrspi_ctrl_model #(.DW(TB_DW), .AW(TB_AW)) ctrl (
    .clk(clk), .k_rise(k_rise), .addr(addr),
    .write_port_sel_n(write_port_sel_n), .wr_data(wr_data),
    .lane_n(lane_n), .read_port_sel_n(read_port_sel_n), .hang(hang));

  // Clock of 40 ns.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Clock counter and read beat monitor.
  always @(posedge clk) cyc <= cyc + 1;

  // Expected edge marker: high in the first clock after reset, alternating.
  always @(posedge clk) ph <= (resetn !== 1'h1) ? 1'h1 : ~ph;

  always @(negedge clk) begin
    if (resetn === 1'h1) begin
      cmp_b(rd_data_oe, out_valid_flag, "drive vs valid");
      cmp_b(k_rise, ph, "edge marker");
      if (out_valid_flag !== 1'h1)
        cmp_d(rd_data, 36'h0, "idle data");
      if (out_valid_flag === 1'h1) begin
        q_dat.push_back(rd_data);
        q_cyc.push_back(cyc);
      end
    end
  end

  // A hung alignment ends the run.
  always @(posedge clk) begin
    if (hang === 1'h1) begin
      n_mismatch++;
      results();
    end
  end

  task automatic fail(input string s);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask : fail

  task automatic cmp_b(input logic g, input logic e, input string s);
    check_count++;
    if (g !== e) fail(s);
  endtask : cmp_b

  task automatic cmp_d(input logic [35:0] g, input logic [35:0] e,
                       input string s);
    check_count++;
    if (g !== e) fail(s);
  endtask : cmp_d

  task automatic cmp_n(input int g, input int e, input string s);
    check_count++;
    if (g != e) fail(s);
  endtask : cmp_n

  // Four lane values per beat, distinct except lanes 0 and 3 of beat 0.
  function automatic logic [3:0][35:0] pat(input logic [8:0] s);
    int b;
    for (b = 0; b < 4; b++) pat[b] = {s, ~s, s ^ 9'h0ff, s + 9'(b)};
  endfunction : pat

  // Expected effect of a write: unmasked lanes of each beat's array.
  task automatic put(input int a, input logic [3:0][35:0] d,
                     input logic [3:0][3:0] m);
    int b;
    int l;
    for (b = 0; b < 4; b++)
      for (l = 0; l < 4; l++)
        if (m[b][l] == 1'h0) mem[a][b][l*9 +: 9] = d[b][l*9 +: 9];
  endtask : put

  // Compares one queued burst with the expected words and cycles.
  task automatic chk_burst(input int a, input int k, input int c0);
    int b;
    for (b = 0; b < 4; b++) begin
      cmp_d(q_dat[k*4+b], mem[a][b], "read beat");
      cmp_n(q_cyc[k*4+b], c0 + b, "beat cycle");
    end
  endtask : chk_burst

  // One read, checked two clocks after its select.
  task automatic t_read(input int a);
    int c0;
    q_dat.delete();
    q_cyc.delete();
    ctrl.rd(19'(a));
    c0 = cyc + 1;
    repeat (6) @(negedge clk);
    cmp_n(q_dat.size(), 4, "beat count");
    chk_burst(a, 0, c0);
  endtask : t_read

  // Two back-to-back full writes read back.
  task automatic t_write();
    ctrl.wr(19'h2, pat(9'h010), '0, 1'b0);
    ctrl.wr(19'h9, pat(9'h040), '0, 1'b0);
    put(2, pat(9'h010), '0);
    put(9, pat(9'h040), '0);
    t_read(2);
    t_read(9);
    $display("test write done");
  endtask : t_write

  // Different lane masks on each beat.
  task automatic t_mask();
    logic [3:0][3:0] m;
    m = {4'hf, 4'ha, 4'h5, 4'he};
    ctrl.wr(19'h2, pat(9'h080), m, 1'b0);
    put(2, pat(9'h080), m);
    t_read(2);
    $display("test mask done");
  endtask : t_mask

  // Select on a negative-edge clock must store nothing.
  task automatic t_skew();
    ctrl.wr(19'h9, pat(9'h0c0), '0, 1'b1);
    t_read(9);
    $display("test skew done");
  endtask : t_skew

  // Gapless reads four clocks apart; a select two clocks in is ignored.
  task automatic t_b2b();
    int c0;
    q_dat.delete();
    q_cyc.delete();
    ctrl.rd(19'h2);
    c0 = cyc + 1;
    @(negedge clk);
    ctrl.rd(19'h9);
    ctrl.rd(19'h2);
    repeat (6) @(negedge clk);
    cmp_n(q_dat.size(), 8, "beat count");
    chk_burst(2, 0, c0);
    chk_burst(9, 1, c0 + 4);
    $display("test back to back done");
  endtask : t_b2b

  // Reset in mid-run clears the arrays and restarts the edge marker.
  task automatic t_rst();
    @(posedge clk);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    foreach (mem[i]) mem[i] = '0;
    @(negedge clk);
    cmp_b(k_rise, 1'h1, "marker after reset");
    cmp_b(out_valid_flag, 1'h0, "valid after reset");
    t_read(2);
    $display("test mid reset done");
  endtask : t_rst

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Main sequence.
  initial begin
    n_mismatch  = 0;
    check_count = 0;
    cyc         = 0;
    resetn      = 1'h0;
    foreach (mem[i]) mem[i] = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    @(negedge clk);
    cmp_b(out_valid_flag, 1'h0, "valid after reset");
    t_read(3);
    $display("test reset done");
    t_write();
    t_mask();
    t_skew();
    t_b2b();
    t_rst();
    results();
  end
endmodule : tb_quad_rate_sram_port_interface
